// ==== adsq_core_model.sv ====
// Behavioural converter core answering each start with one done pulse.
module adsq_core_model
	import adsq_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Handshake with the sequencer.
	input  wire logic             conv_start,
	input  wire logic [CH_W-1:0]  conv_channel,
	input  wire logic             slow,
	output logic                  conv_done,
	output logic [RES_W-1:0]      conv_result
);
	int              cnt;
	logic            busy;
	logic [CH_W-1:0] ch;

	// Count down a prompt or slow conversion, then pulse done once.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy      <= 1'b0;
			cnt       <= 0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) begin
				busy <= 1'b1;
				ch   <= conv_channel;
				cnt  <= slow ? 20 : 4;
			end else if (busy) begin
				if (cnt == 0) begin
					busy      <= 1'b0;
					conv_done <= 1'b1;
				end else begin
					cnt <= cnt - 1;
				end
			end
		end
	end

	// Outside the done cycle the code is inverted, so a late sample cannot pass.
	assign conv_result = conv_done ? (12'hf00 | RES_W'(ch)) : ~(12'hf00 | RES_W'(ch));
endmodule

// ==== adsq_mem_if.sv ====
// Port bundle between the sequencer and its result store.
interface adsq_mem_if;
	import adsq_pkg::*;

	logic             we;
	logic [CH_W-1:0]  waddr;
	logic [RES_W-1:0] wdata;
	logic             ce;
	logic [CH_W-1:0]  caddr;
	logic             re;
	logic [CH_W-1:0]  raddr;
	logic [RES_W-1:0] rdata;

	modport writer (output we, waddr, wdata, ce, caddr, re, raddr, input rdata);
	modport store  (input we, waddr, wdata, ce, caddr, re, raddr, output rdata);
endinterface

// ==== adsq_pkg.sv ====
// Shared constants, types and helpers of the converter scan sequencer.
package adsq_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int RES_W  = 12;
	localparam int NUM_CH = 16;
	localparam int CH_W   = 4;
	localparam int DED_W  = 6;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CTRL       = 32'hffff_d400;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 32'hffff_d404;
	localparam logic [ADDR_W-1:0] ADDR_CHSEL      = 32'hffff_d408;
	localparam logic [ADDR_W-1:0] ADDR_RESULT0    = 32'hffff_d440;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_END = 32'hffff_d480;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_START_BIT = 7;
	localparam int CTRL_MODE_BIT  = 6;
	localparam int CTRL_ACE_BIT   = 5;
	localparam int CTRL_IE_BIT    = 4;
	localparam int CTRL_TRIGGER_START_ENABLE_BIT  = 1;
	localparam int CTRL_TSEL_BIT  = 0;
	localparam int STAT_FLAG_BIT  = 0;
	localparam int STAT_BUSY_BIT  = 1;
	localparam int GROUP_BIT      = 3;
	localparam int IDX_LSB        = 2;
	localparam logic [NUM_CH-1:0] CHSEL_RST = 16'h0000;
	localparam logic [NUM_CH-1:0] DED_MASK  = 16'h0707;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ADSQ_IDLE, ADSQ_CONV, ADSQ_DONE} adsq_state_t;

	typedef struct packed {
		logic            found;
		logic [CH_W-1:0] idx;
	} adsq_pick_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Lowest selected channel at or above the start index.
	function automatic adsq_pick_t adsq_next_chan(input logic [NUM_CH-1:0] mask,
			input logic [CH_W:0] from);
		adsq_pick_t p;
		p = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (!p.found && (i >= int'(from)) && mask[i]) begin
				p.found = 1'b1;
				p.idx   = CH_W'(i);
			end
		end
		return p;
	endfunction

	// True for an aligned address inside the result window.
	function automatic logic adsq_is_result(input logic [ADDR_W-1:0] a);
		return (a >= ADDR_RESULT0) && (a < ADDR_RESULT_END) && (a[1:0] == 2'h0);
	endfunction

endpackage

// ==== adsq_result_mem.sv ====
// Per-channel result store with registered read and clear port.
module adsq_result_mem
	import adsq_pkg::*;
(
	// Clock and reset.
	input wire logic     clk,
	input wire logic     sys_rst,
	// Access from the sequencer.
	adsq_mem_if.store    mem
);

	logic [RES_W-1:0] cells [NUM_CH];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// A fresh result beats a read-clear of the same cell, so no sample is lost.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CH; i++) cells[i] <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (mem.we && (mem.waddr == CH_W'(i))) begin
					cells[i] <= mem.wdata;
				end else if (mem.ce && (mem.caddr == CH_W'(i))) begin
					cells[i] <= '0;
				end
			end
		end
	end

	// Read data leave from a register, sampled before a clear lands.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem.rdata <= '0;
		end else if (mem.re) begin
			mem.rdata <= cells[mem.raddr];
		end
	end

endmodule

// ==== adsq_top.sv ====
// Scan sequencer top: register slave, scan control and converter handshake.
//
// Function
// - Single-cycle scan converts each selected channel once, then stops.
// - Hardware clears the start bit when a single-cycle scan ends.
// - Continuous scan repeats the selected channels until start bit is cleared.
// - Channels 0-2 and 8-10 sample together on dedicated hold stages.
// - Shared hold stage for channels 3-7, another for channels 11-15.
// - Every result is twelve bits wide.
// - Four first-timer lines may start a scan.
// - Three second-timer lines may start a scan.
// - Trigger enable low blocks pin and timer start sources.
// - Writing one to the start bit starts conversion.
// - Start bit low halts conversion.
// - Mode bit zero gives single-cycle scan, one gives continuous scan.
// - With auto-clear set, reading a result clears it.
// - End interrupt appears only when its enable is set.
// - Control bits: start 7, mode 6, clear 5, interrupt 4, trigger 1, source 0.
// - End flag sets on scan completion; software clears it by writing zero.
// - Channel select holds one bit per channel; only set ones convert.
module adsq_top
	import adsq_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Timer and pin start sources.
	input  wire logic              timer_general_trigger_a,
	input  wire logic              timer_ch0_trigger_a,
	input  wire logic              timer_ch4a_trigger_a,
	input  wire logic              timer_ch4b_trigger_a,
	input  wire logic              timer_general_trigger_b,
	input  wire logic              timer_ch4a_trigger_b,
	input  wire logic              timer_ch4b_trigger_b,
	input  wire logic              external_conv_trigger,
	// Converter core handshake.
	output logic                   conv_start,
	output logic [CH_W-1:0]        conv_channel,
	input  wire logic              conv_done,
	input  wire logic [RES_W-1:0]  conv_result,
	// Sample-and-hold strobes.
	output logic [DED_W-1:0]       dedicated_sample,
	output logic [1:0]             shared_sample,
	// Interrupt.
	output logic                   conv_end_irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                conversion_start_bit;
	logic                scan_mode_select;
	logic                read_auto_clear_enable;
	logic                end_interrupt_enable;
	logic                trigger_start_enable;
	logic                source_select;
	logic                conversion_end_flag;
	logic [NUM_CH-1:0]   channel_select_reg;
	adsq_state_t         state;
	logic [CH_W-1:0]     cur_ch;
	adsq_pick_t          pick;
	logic                issue;
	logic                scan_done;
	logic                trig_req;
	logic                trig_set;
	logic                aw_held;
	logic                w_held;
	logic [ADDR_W-1:0]   aw_addr;
	logic [DATA_W-1:0]   w_data;
	logic [3:0]          w_strb;
	logic                wr_fire;
	logic                wr_mapped;
	logic                ctrl_we;
	logic                stat_we;
	logic                ar_fire;
	logic                rd_pend;
	logic [ADDR_W-1:0]   rd_addr;
	logic [DATA_W-1:0]   next_rdata;
	logic                next_rerr;

	adsq_mem_if mem_bus ();

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	adsq_trigger u_trigger (
		.clk                     (clk),
		.sys_rst                 (sys_rst),
		.trigger_start_enable    (trigger_start_enable),
		.source_select           (source_select),
		.timer_general_trigger_a (timer_general_trigger_a),
		.timer_ch0_trigger_a     (timer_ch0_trigger_a),
		.timer_ch4a_trigger_a    (timer_ch4a_trigger_a),
		.timer_ch4b_trigger_a    (timer_ch4b_trigger_a),
		.timer_general_trigger_b (timer_general_trigger_b),
		.timer_ch4a_trigger_b    (timer_ch4a_trigger_b),
		.timer_ch4b_trigger_b    (timer_ch4b_trigger_b),
		.external_conv_trigger   (external_conv_trigger),
		.start_request           (trig_req)
	);

	adsq_result_mem u_mem (
		.clk     (clk),
		.sys_rst (sys_rst),
		.mem     (mem_bus.store)
	);

	// ------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------
	// Address and data are caught independently; the write lands once both are held.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wr_mapped     = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_STATUS) ||
		(aw_addr == ADDR_CHSEL) || adsq_is_result(aw_addr);
	assign ctrl_we       = wr_fire && (aw_addr == ADDR_CTRL) && w_strb[0];
	assign stat_we       = wr_fire && (aw_addr == ADDR_STATUS) && w_strb[0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control and select registers
	// ------------------------------------------------------------
	// Mode and enable bits follow software writes only.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scan_mode_select       <= 1'b0;
			read_auto_clear_enable <= 1'b0;
			end_interrupt_enable   <= 1'b0;
			trigger_start_enable   <= 1'b0;
			source_select          <= 1'b0;
		end else if (ctrl_we) begin
			scan_mode_select       <= w_data[CTRL_MODE_BIT];
			read_auto_clear_enable <= w_data[CTRL_ACE_BIT];
			end_interrupt_enable   <= w_data[CTRL_IE_BIT];
			trigger_start_enable   <= w_data[CTRL_TRIGGER_START_ENABLE_BIT];
			source_select          <= w_data[CTRL_TSEL_BIT];
		end
	end

	// Byte lanes 0 and 1 carry the channel select bits.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			channel_select_reg <= CHSEL_RST;
		end else if (wr_fire && (aw_addr == ADDR_CHSEL)) begin
			if (w_strb[0]) channel_select_reg[7:0] <= w_data[7:0];
			if (w_strb[1]) channel_select_reg[15:8] <= w_data[15:8];
		end
	end

	// Only an idle sequencer with the start bit low takes a hardware trigger.
	assign trig_set = trig_req && (state == ADSQ_IDLE) && !conversion_start_bit;

	// Any set beats any clear, so a trigger is never swallowed by a write of zero.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conversion_start_bit <= 1'b0;
		end else if (trig_set || (ctrl_we && w_data[CTRL_START_BIT])) begin
			conversion_start_bit <= 1'b1;
		end else if (ctrl_we || (scan_done && !scan_mode_select)) begin
			conversion_start_bit <= 1'b0;
		end
	end

	// End flag: completion beats a software write of zero in the same cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conversion_end_flag <= 1'b0;
		end else if (scan_done) begin
			conversion_end_flag <= 1'b1;
		end else if (stat_we && !w_data[STAT_FLAG_BIT]) begin
			conversion_end_flag <= 1'b0;
		end
	end

	assign conv_end_irq = conversion_end_flag && end_interrupt_enable;

	// ------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------
	// Pick the lowest selected channel above the last one converted, or from channel 0 when idle.
	always_comb begin
		pick  = adsq_next_chan(channel_select_reg,
			(state == ADSQ_IDLE) ? '0 : ({1'b0, cur_ch} + 5'h01));
		issue = conversion_start_bit &&
			((state == ADSQ_IDLE) || ((state == ADSQ_CONV) && conv_done));
	end

	assign scan_done = (state == ADSQ_DONE);

	// Each conversion that finishes while the start bit is high goes straight to its own channel cell.
	assign mem_bus.we    = (state == ADSQ_CONV) && conversion_start_bit && conv_done;
	assign mem_bus.waddr = cur_ch;
	assign mem_bus.wdata = conv_result;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state            <= ADSQ_IDLE;
			cur_ch           <= '0;
			conv_start       <= 1'b0;
			conv_channel     <= '0;
			dedicated_sample <= '0;
			shared_sample    <= '0;
		end else begin
			conv_start       <= 1'b0;
			dedicated_sample <= '0;
			shared_sample    <= '0;
			case (state)
				ADSQ_IDLE: begin
					if (conversion_start_bit) begin
						// Dedicated stages freeze all their selected channels at once.
						dedicated_sample <= {channel_select_reg[10:8],
							channel_select_reg[2:0]};
						state <= pick.found ? ADSQ_CONV : ADSQ_DONE;
					end
				end
				ADSQ_CONV: begin
					if (!conversion_start_bit) begin
						state <= ADSQ_IDLE;
					end else if (conv_done && !pick.found) begin
						state <= ADSQ_DONE;
					end
				end
				ADSQ_DONE: begin
					// Continuous mode re-enters idle with the start bit still high.
					state <= ADSQ_IDLE;
				end
				default: begin
					state <= ADSQ_IDLE;
				end
			endcase
			if (issue && pick.found) begin
				conv_start   <= 1'b1;
				conv_channel <= pick.idx;
				cur_ch       <= pick.idx;
				if (!DED_MASK[pick.idx]) begin
					shared_sample[pick.idx[GROUP_BIT]] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read channels
	// ------------------------------------------------------------
	// One read in flight; result data arrive from the store a cycle later.
	assign s_axi_arready = !rd_pend && !s_axi_rvalid;
	assign ar_fire       = s_axi_arvalid && s_axi_arready;
	assign mem_bus.re    = ar_fire;
	assign mem_bus.raddr = s_axi_araddr[IDX_LSB+CH_W-1:IDX_LSB];
	assign mem_bus.ce    = ar_fire && read_auto_clear_enable &&
		adsq_is_result(s_axi_araddr);
	assign mem_bus.caddr = s_axi_araddr[IDX_LSB+CH_W-1:IDX_LSB];

	always_comb begin
		next_rdata = '0;
		next_rerr  = 1'b0;
		if (rd_addr == ADDR_CTRL) begin
			next_rdata[CTRL_START_BIT] = conversion_start_bit;
			next_rdata[CTRL_MODE_BIT]  = scan_mode_select;
			next_rdata[CTRL_ACE_BIT]   = read_auto_clear_enable;
			next_rdata[CTRL_IE_BIT]    = end_interrupt_enable;
			next_rdata[CTRL_TRIGGER_START_ENABLE_BIT]  = trigger_start_enable;
			next_rdata[CTRL_TSEL_BIT]  = source_select;
		end else if (rd_addr == ADDR_STATUS) begin
			next_rdata[STAT_FLAG_BIT] = conversion_end_flag;
			next_rdata[STAT_BUSY_BIT] = (state != ADSQ_IDLE);
		end else if (rd_addr == ADDR_CHSEL) begin
			next_rdata[NUM_CH-1:0] = channel_select_reg;
		end else if (adsq_is_result(rd_addr)) begin
			next_rdata[RES_W-1:0] = mem_bus.rdata;
		end else begin
			next_rerr = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_pend      <= 1'b0;
			rd_addr      <= '0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			if (ar_fire) begin
				rd_pend <= 1'b1;
				rd_addr <= s_axi_araddr;
			end
			if (rd_pend) begin
				rd_pend      <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ==== adsq_top_chk.sv ====
// Port-level assertions for the converter scan sequencer top.
module adsq_top_chk
	import adsq_pkg::*;
(
	// Clock and reset.
	input wire logic              clk,
	input wire logic              sys_rst,
	// Register bus.
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// Converter side.
	input wire logic              conv_start,
	input wire logic [CH_W-1:0]   conv_channel,
	input wire logic [DED_W-1:0]  dedicated_sample,
	input wire logic [1:0]        shared_sample,
	input wire logic              conv_end_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	// Held address and data apply one edge after the take; the answer stands the edge after.
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response missing");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_bus_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read latency wrong");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

	// ------------------------------------------------------------
	// Scan strobes
	// ------------------------------------------------------------
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	a_chan_hold: assert property (!conv_start |-> $stable(conv_channel))
		else $error("channel moved without start");
	a_shared_low: assert property (shared_sample[0]
		|-> conv_start && !conv_channel[3] && !DED_MASK[conv_channel])
		else $error("low shared stage misused");
	a_shared_high: assert property (shared_sample[1]
		|-> conv_start && conv_channel[3] && !DED_MASK[conv_channel])
		else $error("high shared stage misused");
	a_ded_first: assert property (|dedicated_sample |-> conv_start)
		else $error("dedicated strobe without start");

	// Main scenarios seen.
	c_conv: cover property (conv_start);
	c_irq: cover property ($rose(conv_end_irq));
	c_shared: cover property (shared_sample[0]);
endmodule

// ==== adsq_top_tb.sv ====
// Self-checking bench for the converter scan sequencer.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module adsq_top_tb import adsq_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, slow = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, conv_start, conv_done, conv_end_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, shared_sample, r;
	logic [CH_W-1:0] conv_channel;
	logic [RES_W-1:0] conv_result;
	logic [DED_W-1:0] dedicated_sample, ded;
	logic [7:0] trig = 0;
	logic timer_general_trigger_a, timer_ch0_trigger_a, timer_ch4a_trigger_a;
	logic timer_ch4b_trigger_a, timer_general_trigger_b, timer_ch4a_trigger_b;
	logic timer_ch4b_trigger_b, external_conv_trigger;
	int error_cnt = 0, samples_checked = 0, starts = 0, cyc = 0, s0;

	assign {external_conv_trigger, timer_ch4b_trigger_b, timer_ch4a_trigger_b,
		timer_general_trigger_b, timer_ch4b_trigger_a, timer_ch4a_trigger_a,
		timer_ch0_trigger_a, timer_general_trigger_a} = trig;

	adsq_top u_adsq_top (.*);
	adsq_core_model u_adsq_core_model (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
		.conv_channel(conv_channel), .slow(slow), .conv_done(conv_done),
		.conv_result(conv_result));

	// ------------------------------------------------------------
	// Clock, monitor and hang guard
	// ------------------------------------------------------------
	always #5 clk = ~clk;

	// Count conversions and keep the last scan-start strobe pattern.
	always @(posedge clk) begin
		if (conv_start)
			starts++;
		if (dedicated_sample != 0)
			ded = dedicated_sample;
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			results;
		end
	end

	task automatic results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				break;
		end
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] e);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				break;
		end
		d = s_axi_rdata;
		e = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Poll the end flag, as software would; the hang guard bounds it.
	task automatic scan_wait;
		do
			rd(ADDR_STATUS, v, r);
		while (v[0] !== 1'b1);
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		trig[i] <= 1'b1;
		@(posedge clk);
		trig <= 8'h00;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL, v, r);
		`CHK(v, 32'h0000_0000)
		rd(ADDR_CHSEL, v, r);
		`CHK(v, 32'h0000_0000)
		rd(32'hffff_d410, v, r);
		`CHK(r, RESP_SLVERR)
		wr(32'hffff_d410, 32'h0000_0080, RESP_SLVERR);
		// Single scan of four channels by software start.
		wr(ADDR_CHSEL, 32'h0000_000f, RESP_OKAY);
		s0 = starts;
		wr(ADDR_CTRL, 32'h0000_0080, RESP_OKAY);
		scan_wait;
		`CHK(starts - s0, 4)
		`CHK(ded, 6'h07)
		`CHK(conv_end_irq, 1'b0)
		rd(ADDR_CTRL, v, r);
		`CHK(v, 32'h0000_0000)
		for (int n = 0; n < 4; n++) begin
			rd(ADDR_RESULT0 + 4 * n, v, r);
			`CHK(v, 32'h0000_0f00 | n)
		end
		rd(ADDR_RESULT0 + 32'h4, v, r);
		`CHK(v, 32'h0000_0f01)
		// Interrupt follows its enable; flag clears by writing zero.
		wr(ADDR_CTRL, 32'h0000_0010, RESP_OKAY);
		@(posedge clk);
		`CHK(conv_end_irq, 1'b1)
		wr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_STATUS, v, r);
		`CHK(v[0], 1'b0)
		`CHK(conv_end_irq, 1'b0)
		// Auto-clear on read.
		wr(ADDR_CTRL, 32'h0000_0020, RESP_OKAY);
		rd(ADDR_RESULT0 + 32'h8, v, r);
		`CHK(v, 32'h0000_0f02)
		rd(ADDR_RESULT0 + 32'h8, v, r);
		`CHK(v, 32'h0000_0000)
		// Continuous scan with a slow core, then abort.
		slow <= 1'b1;
		wr(ADDR_CHSEL, 32'h0000_0100, RESP_OKAY);
		s0 = starts;
		wr(ADDR_CTRL, 32'h0000_00c0, RESP_OKAY);
		while (starts - s0 < 3)
			@(posedge clk);
		`CHK(ded, 6'h08)
		wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
		repeat (40) @(posedge clk);
		s0 = starts;
		repeat (60) @(posedge clk);
		`CHK(starts, s0)
		rd(ADDR_STATUS, v, r);
		`CHK(v[0], 1'b1)
		wr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		// Triggers ignored while their gate is off.
		slow <= 1'b0;
		wr(ADDR_CHSEL, 32'h0000_0001, RESP_OKAY);
		for (int i = 0; i < 8; i++)
			pulse(i);
		repeat (20) @(posedge clk);
		`CHK(starts, s0)
		// Each line starts one scan; a second pulse mid-scan is ignored.
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CTRL, (i == 7) ? 32'h0000_0003 : 32'h0000_0002, RESP_OKAY);
			s0 = starts;
			pulse(i);
			repeat (2) @(posedge clk);
			pulse(i);
			scan_wait;
			repeat (10) @(posedge clk);
			`CHK(starts - s0, 1)
			wr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		end
		results;
	end
endmodule

bind adsq_top adsq_top_chk u_adsq_top_chk (.*);

// ==== adsq_trigger.sv ====
// Start-trigger gate and edge detector for timer and pin sources.
module adsq_trigger
	import adsq_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic sys_rst,
	// Control.
	input  wire logic trigger_start_enable,
	input  wire logic source_select,
	// First timer unit lines.
	input  wire logic timer_general_trigger_a,
	input  wire logic timer_ch0_trigger_a,
	input  wire logic timer_ch4a_trigger_a,
	input  wire logic timer_ch4b_trigger_a,
	// Second timer unit lines.
	input  wire logic timer_general_trigger_b,
	input  wire logic timer_ch4a_trigger_b,
	input  wire logic timer_ch4b_trigger_b,
	// External pin.
	input  wire logic external_conv_trigger,
	// Result.
	output logic      start_request
);

	logic [7:0] lines;
	logic [7:0] prev;
	logic [7:0] rise;

	// Collect all sources; bit 7 is the pin, the rest are timer lines.
	assign lines = {external_conv_trigger, timer_ch4b_trigger_b, timer_ch4a_trigger_b,
		timer_general_trigger_b, timer_ch4b_trigger_a, timer_ch4a_trigger_a,
		timer_ch0_trigger_a, timer_general_trigger_a};
	assign rise = lines & ~prev;

	// Remember last levels so a held line starts only one scan.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev <= '0;
		end else begin
			prev <= lines;
		end
	end

	// Gate: enable off blocks all hardware sources.
	always_comb begin
		start_request = 1'b0;
		if (trigger_start_enable) begin
			start_request = source_select ? rise[7] : (|rise[6:0]);
		end
	end

endmodule
